//--- shared/line_regs_pkg.sv
// Register offsets, field positions and timing constants of the mask bank.
package line_regs_pkg;
    // Register byte offsets on the control port.
    localparam logic [7:0] TIMER_IRQ_STATUS_OFS = 8'h12;
    localparam logic [7:0] ALARM_LOOP_IRQ_STATUS_OFS = 8'h13;
    localparam logic [7:0] MISC_IRQ_STATUS_OFS = 8'h14;
    localparam logic [7:0] TIMER_IRQ_MASK_OFS = 8'h15;
    localparam logic [7:0] ALARM_LOOP_IRQ_MASK_OFS = 8'h16;
    localparam logic [7:0] MISC_IRQ_MASK_OFS = 8'h17;
    localparam logic [7:0] TONE_DIGIT_STATUS_OFS = 8'h18;
    localparam logic [7:0] INDIRECT_DATA_LOW_OFS = 8'h1c;
    localparam logic [7:0] INDIRECT_DATA_HIGH_OFS = 8'h1d;
    localparam logic [7:0] INDIRECT_ADDRESS_OFS = 8'h1e;
    localparam logic [7:0] INDIRECT_STATUS_OFS = 8'h1f;
    // Field positions of the third mask and status register.
    localparam int TONE_DETECT_BIT = 0;
    localparam int INDIRECT_DONE_BIT = 1;
    localparam int CAL_ERROR_BIT = 2;
    localparam int MISC_BITS = 3;
    // Field positions of the tone digit status register.
    localparam int DIGIT_PRESENT_BIT = 4;
    localparam int DIGIT_CODE_LSB = 0;
    localparam int DIGIT_CODE_W = 4;
    // Reset values.
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [15:0] INDIRECT_DATA_RESET = 16'h0000;
    localparam logic [7:0] INDIRECT_ADDRESS_RESET = 8'h00;
    // Indirect update period and its count of 5 ns clock cycles.
    localparam int CLK_PERIOD_PS = 5000;
    localparam int UPDATE_PERIOD_NS = 62500;
    localparam int UPDATE_CYCLES = (UPDATE_PERIOD_NS * 1000) / CLK_PERIOD_PS;
    localparam int TICK_COUNT_W = 16;
endpackage : line_regs_pkg

//--- hw/indirect_store.sv
// Indirect register array written and read on the update tick.
`timescale 1ns/1ps
`default_nettype none
module indirect_store #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 16
) (
    // Clock and clock enable.
    input wire logic clk_i,
    input wire logic ce_i,
    // Access.
    input wire logic wr_en_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] data_i,
    output logic [DATA_W-1:0] rdata_o
);
    if (ADDR_W < 1 || ADDR_W > 16 || DATA_W < 1) begin : g_bad_size
        $error("Store address or data width out of range.");
    end

    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge clk_i) begin
        if (ce_i && wr_en_i) begin
            mem[addr_i] <= data_i;
        end
    end

    assign rdata_o = mem[addr_i];
endmodule : indirect_store
`default_nettype wire

//--- hw/irq_mask_dual_tone_keypad_indirect_regs.sv
// Interrupt masks, tone digit status and indirect register window.
//
// How it works
// - Timer mask bits: meter, ring, osc B, osc A.
// - Mask 0 blocks, 1 passes; all read/write.
// - Power alarm six..one masks sit in bits 7:2.
// - Bit 1 loop change, bit 0 ring trip.
// - Third mask: calibration, indirect done, tone detect.
// - Bit 4 shows a digit is being detected.
// - Keys 1-9 code 1-9, key 0 codes 1010.
// - Star, pound, A, B, C follow; D is 0000.
// - Indirect data split into low and high bytes.
// - Data then address write stores on next tick.
// - Address-only write loads data on next tick.
// - Indirect transfers happen only on the tick.
// - Indirect address is an eight-bit read/write field.
// - Writing one clears a pending flag; zero keeps.
// - Serviced transfer sets the indirect done flag.
// - Pending bit high from address write to completion.
`timescale 1ns/1ps
`default_nettype none
module irq_mask_dual_tone_keypad_indirect_regs #(
    parameter int UPDATE_CYCLES = line_regs_pkg::UPDATE_CYCLES
) (
    // Clock, reset and enable.
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Register access from the control port.
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    // Event pulses from the line logic.
    input wire logic [7:0] timer_evt_i,
    input wire logic [7:0] alarm_loop_evt_i,
    input wire logic cal_error_evt_i,
    input wire logic tone_evt_i,
    // Tone detector state.
    input wire logic digit_present_i,
    input wire logic [3:0] digit_code_i,
    // Interrupt request.
    output logic irq_o
);
    localparam int CW = line_regs_pkg::TICK_COUNT_W;
    localparam int MB = line_regs_pkg::MISC_BITS;

    if (UPDATE_CYCLES < 1 || UPDATE_CYCLES > (1 << CW)) begin : g_bad_period
        $error("UPDATE_CYCLES does not fit the tick counter.");
    end

    typedef struct packed {
        logic [7:0] timer_irq_mask;
        logic [7:0] alarm_loop_irq_mask;
        logic [MB-1:0] misc_irq_mask;
        logic [7:0] timer_flags;
        logic [7:0] alarm_loop_flags;
        logic [MB-1:0] misc_flags;
        logic digit_present;
        logic [3:0] digit_code;
        logic [15:0] indirect_data;
        logic [7:0] indirect_addr;
        logic indirect_pending;
        logic data_written;
        logic [CW-1:0] tick_count;
        logic [7:0] rdata;
        logic rvalid;
        logic irq;
    } state_type;

    localparam state_type RESET_STATE = '{
        timer_irq_mask: line_regs_pkg::MASK_RESET,
        alarm_loop_irq_mask: line_regs_pkg::MASK_RESET,
        misc_irq_mask: line_regs_pkg::MASK_RESET[MB-1:0],
        indirect_data: line_regs_pkg::INDIRECT_DATA_RESET,
        indirect_addr: line_regs_pkg::INDIRECT_ADDRESS_RESET,
        default: '0
    };

    state_type st;
    state_type next_st;
    logic tick;
    logic store_wr;
    logic [15:0] store_rdata;
    logic [MB-1:0] misc_evt;

    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    // Byte that a register read returns; unmapped offsets read zero.
    function automatic logic [7:0] read_mux(input state_type s,
                                            input logic [7:0] a);
        logic [7:0] r;
        r = 8'h00;
        case (a)
            line_regs_pkg::TIMER_IRQ_STATUS_OFS: r = s.timer_flags;
            line_regs_pkg::ALARM_LOOP_IRQ_STATUS_OFS: r = s.alarm_loop_flags;
            line_regs_pkg::MISC_IRQ_STATUS_OFS: r = 8'(s.misc_flags);
            line_regs_pkg::TIMER_IRQ_MASK_OFS: r = s.timer_irq_mask;
            line_regs_pkg::ALARM_LOOP_IRQ_MASK_OFS: begin
                r = s.alarm_loop_irq_mask;
            end
            line_regs_pkg::MISC_IRQ_MASK_OFS: r = 8'(s.misc_irq_mask);
            line_regs_pkg::TONE_DIGIT_STATUS_OFS: begin
                r = 8'({s.digit_present, s.digit_code});
            end
            line_regs_pkg::INDIRECT_DATA_LOW_OFS: r = s.indirect_data[7:0];
            line_regs_pkg::INDIRECT_DATA_HIGH_OFS: r = s.indirect_data[15:8];
            line_regs_pkg::INDIRECT_ADDRESS_OFS: r = s.indirect_addr;
            line_regs_pkg::INDIRECT_STATUS_OFS: begin
                r = 8'(s.indirect_pending);
            end
            default: r = 8'h00;
        endcase
        return r;
    endfunction : read_mux

    // True when a register write hits the given offset.
    function automatic logic hit(input logic w, input logic [7:0] a,
                                 input logic [7:0] ofs);
        return w && (a == ofs);
    endfunction : hit

    indirect_store #(
        .ADDR_W(8),
        .DATA_W(16)
    ) u_store (
        .clk_i(clk_i),
        .ce_i(ce_i),
        .wr_en_i(store_wr),
        .addr_i(st.indirect_addr),
        .data_i(st.indirect_data),
        .rdata_o(store_rdata)
    );

    assign tick = ce_i && (st.tick_count == '0);
    assign store_wr = tick && st.indirect_pending && st.data_written;

    always_comb begin
        next_st = st;
        misc_evt = '0;
        next_st.rvalid = 1'b0;
        // Free running update tick.
        if (st.tick_count == '0) begin
            next_st.tick_count = CW'(UPDATE_CYCLES - 1);
        end else begin
            next_st.tick_count = st.tick_count - CW'(1);
        end
        // Pending transfer is serviced only on the tick.
        if (tick && st.indirect_pending) begin
            if (!st.data_written) begin
                next_st.indirect_data = store_rdata;
            end
            next_st.indirect_pending = 1'b0;
            next_st.data_written = 1'b0;
            misc_evt[line_regs_pkg::INDIRECT_DONE_BIT] = 1'b1;
        end
        misc_evt[line_regs_pkg::CAL_ERROR_BIT] = cal_error_evt_i;
        misc_evt[line_regs_pkg::TONE_DETECT_BIT] = tone_evt_i;
        // Write-one-to-clear, with a same-cycle event winning.
        next_st.timer_flags = timer_evt_i | (st.timer_flags & ~(
            hit(wr_i, addr_i, line_regs_pkg::TIMER_IRQ_STATUS_OFS)
            ? wdata_i : 8'h00));
        next_st.alarm_loop_flags = alarm_loop_evt_i | (st.alarm_loop_flags
            & ~(hit(wr_i, addr_i, line_regs_pkg::ALARM_LOOP_IRQ_STATUS_OFS)
            ? wdata_i : 8'h00));
        next_st.misc_flags = misc_evt | (st.misc_flags & ~(
            hit(wr_i, addr_i, line_regs_pkg::MISC_IRQ_STATUS_OFS)
            ? wdata_i[MB-1:0] : '0));
        // Host register writes.
        if (hit(wr_i, addr_i, line_regs_pkg::TIMER_IRQ_MASK_OFS)) begin
            next_st.timer_irq_mask = wdata_i;
        end
        if (hit(wr_i, addr_i, line_regs_pkg::ALARM_LOOP_IRQ_MASK_OFS)) begin
            next_st.alarm_loop_irq_mask = wdata_i;
        end
        if (hit(wr_i, addr_i, line_regs_pkg::MISC_IRQ_MASK_OFS)) begin
            next_st.misc_irq_mask = wdata_i[MB-1:0];
        end
        if (hit(wr_i, addr_i, line_regs_pkg::INDIRECT_DATA_LOW_OFS)) begin
            next_st.indirect_data[7:0] = wdata_i;
            next_st.data_written = 1'b1;
        end
        if (hit(wr_i, addr_i, line_regs_pkg::INDIRECT_DATA_HIGH_OFS)) begin
            next_st.indirect_data[15:8] = wdata_i;
            next_st.data_written = 1'b1;
        end
        if (hit(wr_i, addr_i, line_regs_pkg::INDIRECT_ADDRESS_OFS)) begin
            next_st.indirect_addr = wdata_i;
            next_st.indirect_pending = 1'b1;
        end
        // Tone detector state is sampled on every cycle with ce_i high.
        next_st.digit_present = digit_present_i;
        next_st.digit_code = digit_code_i;
        if (rd_i) begin
            next_st.rdata = read_mux(st, addr_i);
            next_st.rvalid = 1'b1;
        end
        next_st.irq = |(next_st.timer_flags & next_st.timer_irq_mask)
            || |(next_st.alarm_loop_flags & next_st.alarm_loop_irq_mask)
            || |(next_st.misc_flags & next_st.misc_irq_mask);
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= RESET_STATE;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign rdata_o = st.rdata;
    assign rvalid_o = st.rvalid;
    assign irq_o = st.irq;

    a_timer_mask_write: assert property (
        ce_i && wr_i && addr_i == line_regs_pkg::TIMER_IRQ_MASK_OFS
        |=> st.timer_irq_mask == $past(wdata_i))
        else $error("Timer mask did not take the written byte.");

    a_alarm_mask_write: assert property (
        ce_i && wr_i && addr_i == line_regs_pkg::ALARM_LOOP_IRQ_MASK_OFS
        |=> st.alarm_loop_irq_mask == $past(wdata_i))
        else $error("Alarm and loop mask did not take the written byte.");

    a_misc_mask_read: assert property (
        ce_i && rd_i && addr_i == line_regs_pkg::MISC_IRQ_MASK_OFS
        |=> rvalid_o && rdata_o[7:MB] == '0
        && rdata_o[MB-1:0] == $past(st.misc_irq_mask))
        else $error("Third mask read back wrong or upper bits set.");

    a_digit_status_read: assert property (
        ce_i && rd_i && addr_i == line_regs_pkg::TONE_DIGIT_STATUS_OFS
        |=> rdata_o == {3'h0, $past(st.digit_present),
        $past(st.digit_code)})
        else $error("Tone digit status read back wrong.");

    a_pending_set: assert property (
        ce_i && wr_i && addr_i == line_regs_pkg::INDIRECT_ADDRESS_OFS
        |=> st.indirect_pending)
        else $error("Address write did not raise the pending bit.");

    a_pending_holds: assert property (
        st.indirect_pending && !tick |=> st.indirect_pending)
        else $error("Indirect transfer finished without a tick.");

    a_done_on_tick: assert property (
        tick && st.indirect_pending && !wr_i
        |=> !st.indirect_pending
        && st.misc_flags[line_regs_pkg::INDIRECT_DONE_BIT])
        else $error("Serviced transfer did not set the done flag.");

    a_read_loads_data: assert property (
        tick && st.indirect_pending && !st.data_written && !wr_i
        |=> st.indirect_data == $past(store_rdata))
        else $error("Indirect read did not load the data bytes.");

    a_write_stores: assert property (
        tick && st.indirect_pending && st.data_written && !wr_i
        |=> st.indirect_data == $past(st.indirect_data)
        && store_rdata == st.indirect_data)
        else $error("Indirect write did not reach the store.");

    a_flag_clear: assert property (
        ce_i && wr_i && addr_i == line_regs_pkg::TIMER_IRQ_STATUS_OFS
        && timer_evt_i == 8'h00
        |=> st.timer_flags == ($past(st.timer_flags) & ~$past(wdata_i)))
        else $error("Write-one-to-clear misbehaved on timer flags.");

    a_event_sets: assert property (
        ce_i |=> (st.timer_flags & $past(timer_evt_i)) == $past(timer_evt_i))
        else $error("Timer event was lost to a same-cycle clear.");

    a_irq_level: assert property (
        irq_o == (|(st.timer_flags & st.timer_irq_mask)
        || |(st.alarm_loop_flags & st.alarm_loop_irq_mask)
        || |(st.misc_flags & st.misc_irq_mask)))
        else $error("Interrupt output disagrees with flags and masks.");
endmodule : irq_mask_dual_tone_keypad_indirect_regs
`default_nettype wire

//--- verif/host_model.sv
// Host model that drives the register strobe port at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module host_model #(
    parameter int MAX_POLLS = 16
) (
    // Clock.
    input wire logic clk_i,
    // Register port.
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i
);
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end

    // Released address and data lines show the inverse of their last value; both strobes go low.
    task automatic put(input logic [7:0] a, input logic [7:0] d,
                       input logic w);
        @(negedge clk_i);
        wr_o = w;
        rd_o = !w;
        addr_o = a;
        wdata_o = d;
        @(negedge clk_i);
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask : put

    task automatic write(input logic [7:0] a, input logic [7:0] d);
        put(a, d, 1'b1);
    endtask : write

    task automatic read(input logic [7:0] a, output logic [7:0] d,
                        output logic v);
        put(a, 8'h00, 1'b0);
        v = rvalid_i;
        d = rdata_i;
    endtask : read

    // Polls the pending bit so no transfer overlaps the previous one.
    task automatic wait_idle(output int n, output logic ok);
        logic [7:0] d;
        logic v;
        n = 0;
        ok = 1'b0;
        while (!ok && n < MAX_POLLS) begin
            read(line_regs_pkg::INDIRECT_STATUS_OFS, d, v);
            if (v === 1'b1 && d === 8'h00) ok = 1'b1;
            else n++;
        end
    endtask : wait_idle
endmodule : host_model
`default_nettype wire

//--- verif/tb_top.sv
// Testbench for the mask, tone digit and indirect register block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic wr, rd, rvalid, irq, cal_evt, tone_evt, digit_present, ce;
    logic [7:0] addr, wdata, rdata, timer_evt, alarm_evt;
    logic [3:0] digit_code;
    int n_fail = 0;
    int compares = 0;

    always #2.5 clk_i = ~clk_i;

    irq_mask_dual_tone_keypad_indirect_regs #(.UPDATE_CYCLES(20)) dut_u (
        .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce), .wr_i(wr), .rd_i(rd),
        .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid),
        .timer_evt_i(timer_evt), .alarm_loop_evt_i(alarm_evt),
        .cal_error_evt_i(cal_evt), .tone_evt_i(tone_evt),
        .digit_present_i(digit_present), .digit_code_i(digit_code),
        .irq_o(irq));

    host_model #(.MAX_POLLS(16)) host_u (
        .clk_i(clk_i), .wr_o(wr), .rd_o(rd), .addr_o(addr),
        .wdata_o(wdata), .rdata_i(rdata), .rvalid_i(rvalid));

    task automatic tally_and_finish();
        if (n_fail == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        host_u.read(a, d, v);
        check({7'h00, v}, 8'h01);
        check(d, exp);
    endtask : rdchk

    task automatic rw_case();
        logic [7:0] ofs [4];
        logic [7:0] p;
        ofs = '{8'h15, 8'h16, 8'h1c, 8'h1d};
        rdchk(8'h17, 8'h00);
        rdchk(8'h1c, 8'h00);
        for (int i = 0; i < 8; i++) begin
            p = i[0] ? 8'h5a : 8'ha5;
            rdchk(ofs[i/2], i[0] ? 8'ha5 : 8'h00);
            host_u.write(ofs[i/2], p);
            rdchk(ofs[i/2], p);
        end
        host_u.write(8'h17, 8'hff);
        rdchk(8'h17, 8'h07);
        host_u.write(8'h40, 8'hff);
        rdchk(8'h40, 8'h00);
    endtask : rw_case

    task automatic evt_case(input int grp, input int b);
        logic [7:0] m, mo, so;
        m = 8'h01 << b;
        mo = line_regs_pkg::TIMER_IRQ_MASK_OFS + 8'(grp);
        so = line_regs_pkg::TIMER_IRQ_STATUS_OFS + 8'(grp);
        host_u.write(mo, ~m);
        @(negedge clk_i);
        timer_evt = (grp == 0) ? m : 8'h00;
        alarm_evt = (grp == 1) ? m : 8'h00;
        cal_evt = (grp == 2) && m[2];
        tone_evt = (grp == 2) && m[0];
        @(negedge clk_i);
        timer_evt = 8'h00;
        alarm_evt = 8'h00;
        cal_evt = 1'b0;
        tone_evt = 1'b0;
        check({7'h00, irq}, 8'h00);
        host_u.write(so, 8'h00);
        rdchk(so, m);
        host_u.write(mo, m);
        check({7'h00, irq}, 8'h01);
        host_u.write(so, m);
        check({7'h00, irq}, 8'h00);
    endtask : evt_case

    task automatic digit_case();
        for (int c = 0; c < 16; c++) begin
            digit_code = c[3:0];
            digit_present = c[0];
            host_u.write(8'h18, 8'hff);
            rdchk(8'h18, {3'h0, c[0], c[3:0]});
        end
    endtask : digit_case

    task automatic xfer(input logic [7:0] a, input logic [15:0] d,
                        input logic w);
        int n;
        logic ok;
        if (w) begin
            host_u.write(8'h1c, d[7:0]);
            host_u.write(8'h1d, d[15:8]);
        end
        host_u.write(8'h1e, a);
        rdchk(8'h1f, 8'h01);
        host_u.wait_idle(n, ok);
        check({7'h00, ok}, 8'h01);
        if (!ok) tally_and_finish();
        check({7'h00, n >= 3 && n <= 8}, 8'h01);
        check({7'h00, irq}, 8'h01);
        rdchk(8'h14, 8'h02);
        host_u.write(8'h14, 8'h02);
        check({7'h00, irq}, 8'h00);
    endtask : xfer

    task automatic indirect_case();
        int n;
        logic ok;
        host_u.write(8'h1e, 8'h00);
        host_u.wait_idle(n, ok);
        check({7'h00, ok}, 8'h01);
        if (!ok) tally_and_finish();
        host_u.write(8'h14, 8'h02);
        host_u.write(8'h17, 8'h02);
        xfer(8'h05, 16'h1234, 1'b1);
        xfer(8'h09, 16'hbeef, 1'b1);
        xfer(8'h05, 16'h0000, 1'b0);
        rdchk(8'h1c, 8'h34);
        rdchk(8'h1d, 8'h12);
        rdchk(8'h1e, 8'h05);
    endtask : indirect_case

    // With the enable low, a mask write and an event pulse must be ignored.
    task automatic ce_case();
        host_u.write(8'h15, 8'h3c);
        ce = 1'b0;
        host_u.write(8'h15, 8'hc3);
        timer_evt = 8'hff;
        @(negedge clk_i);
        timer_evt = 8'h00;
        ce = 1'b1;
        rdchk(8'h15, 8'h3c);
        rdchk(8'h12, 8'h00);
        check({7'h00, irq}, 8'h00);
    endtask : ce_case

    initial begin
        ce = 1'b1;
        {cal_evt, tone_evt, digit_present} = 3'h0;
        {timer_evt, alarm_evt, digit_code} = 20'h00000;
        repeat (8) @(negedge clk_i);
        rstn_i = 1'b1;
        rdchk(8'h1f, 8'h00);
        rw_case();
        for (int b = 0; b < 8; b++) evt_case(0, b);
        for (int b = 0; b < 8; b++) evt_case(1, b);
        evt_case(2, line_regs_pkg::CAL_ERROR_BIT);
        evt_case(2, line_regs_pkg::TONE_DETECT_BIT);
        digit_case();
        indirect_case();
        ce_case();
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
